// file: hdl/umt_defs.vh
// Register map, field positions, reset values and encodings of the timer
`ifndef UMT_DEFS_VH
`define UMT_DEFS_VH

`define UMT_ADDR_W        4
`define UMT_OFS_CTL       4'h0
`define UMT_OFS_COUNT     4'h1
`define UMT_OFS_PERIOD    4'h2
`define UMT_OFS_CHCTL     4'h3
`define UMT_OFS_CHCMP     4'h4
`define UMT_OFS_SHADOW    4'h5
`define UMT_OFS_STATUS    4'h6
`define UMT_OFS_MASK      4'h7

// Control register fields
`define UMT_CTL_MODE_LO   0
`define UMT_CTL_MODE_HI   1
`define UMT_CTL_IE_BIT    2
`define UMT_CTL_CLR_BIT   3
`define UMT_CTL_RESET     4'h0

// Counting modes
`define UMT_MODE_STOP     2'h0
`define UMT_MODE_UP       2'h1
`define UMT_MODE_CONT     2'h2
`define UMT_MODE_UPDOWN   2'h3

// Shadow load event select, channel control bits 1:0
`define UMT_SHADOW_LOAD_EVENT_SELECT_LO       0
`define UMT_SHADOW_LOAD_EVENT_SELECT_HI       1
`define UMT_LOAD_WRITE    2'h0
`define UMT_LOAD_ZERO_A   2'h1
`define UMT_LOAD_ZERO_B   2'h2
`define UMT_LOAD_PERIOD   2'h3
`define UMT_CHCTL_RESET   2'h0

// Status and mask bits
`define UMT_ST_WRAP       0
`define UMT_ST_CCMP       1
`define UMT_ST_W          2

// XORed into the count for a read that hits the halted-at-period case
`define UMT_CORRUPT_XOR   16'h0001

`endif

// file: hdl/umt_sync_flag.v
// Sticky event flag with write-one-to-clear, set wins over clear
`timescale 1ns/1ps
module umt_sync_flag (
  CLK,
  RST_N,
  set,
  clr,
  flag
);
  input  wire CLK;
  input  wire RST_N;
  input  wire set;
  input  wire clr;
  output wire flag;

  reg flag_reg;

  assign flag = flag_reg;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else if (set) begin
      flag_reg <= 1'b1;
    end else if (clr) begin
      flag_reg <= 1'b0;
    end
  end
endmodule // umt_sync_flag

// file: hdl/umt_shadow_latch.v
// Channel compare shadow latch with load-event selection
`timescale 1ns/1ps
`include "umt_defs.vh"
module umt_shadow_latch #(
  parameter W = 16
) (
  CLK,
  RST_N,
  load_sel,
  up_mode,
  cmp_write,
  cmp_value,
  at_zero,
  at_period,
  shadow
);
  input  wire         CLK;
  input  wire         RST_N;
  input  wire [1:0]   load_sel;
  input  wire         up_mode;
  input  wire         cmp_write;
  input  wire [W-1:0] cmp_value;
  input  wire         at_zero;
  input  wire         at_period;
  output wire [W-1:0] shadow;

  reg  [W-1:0] shadow_reg;
  reg          pending_reg;
  reg          load_now;
  wire         zero_sel;

  assign shadow   = shadow_reg;
  assign zero_sel = (load_sel == `UMT_LOAD_ZERO_A) ||
                    (load_sel == `UMT_LOAD_ZERO_B);

  always @* begin
    load_now = 1'b0;
    case (load_sel)
      `UMT_LOAD_WRITE:  load_now = cmp_write;
      `UMT_LOAD_ZERO_A,
      `UMT_LOAD_ZERO_B: begin
        // Known deviation kept: Up mode ignores the zero wait
        if (up_mode) begin
          load_now = cmp_write;
        end else begin
          load_now = pending_reg && at_zero;
        end
      end
      `UMT_LOAD_PERIOD: load_now = pending_reg && at_period;
      default:          load_now = 1'b0;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shadow_reg  <= {W{1'b0}};
      pending_reg <= 1'b0;
    end else begin
      if (load_now) begin
        shadow_reg <= cmp_value;
      end
      if (cmp_write && !(zero_sel && up_mode) &&
          load_sel != `UMT_LOAD_WRITE) begin
        pending_reg <= 1'b1;
      end else if (load_now) begin
        pending_reg <= 1'b0;
      end
    end
  end
endmodule // umt_shadow_latch

// file: hdl/umt_timer.v
// Up mode timer with compare shadow latch and Wishbone register access
`timescale 1ns/1ps
`include "umt_defs.vh"
// Function
// - A count read while halted at the period in Up mode may be wrong.
// - Settings 1 and 2 load the shadow when the running count reaches zero.
// - In Up mode those settings load a new compare value at once.
// - A control enable bit lets the timer raise an interrupt to software.
module umt_timer #(
  parameter W = 16
) (
  CLK,
  RST_N,
  ADR_I,
  DAT_I,
  DAT_O,
  WE_I,
  SEL_I,
  STB_I,
  CYC_I,
  ACK_O,
  ERR_O,
  IRQ
);
  input  wire        CLK;
  input  wire        RST_N;
  input  wire [31:0] ADR_I;
  input  wire [31:0] DAT_I;
  output wire [31:0] DAT_O;
  input  wire        WE_I;
  input  wire [3:0]  SEL_I;
  input  wire        STB_I;
  input  wire        CYC_I;
  output wire        ACK_O;
  output wire        ERR_O;
  output wire        IRQ;

  reg  [3:0]   ctl_reg;
  reg  [W-1:0] count_reg;
  reg  [W-1:0] count_next;
  reg          dir_down_reg;
  reg  [W-1:0] period_reg;
  reg  [1:0]   chctl_reg;
  reg  [W-1:0] chcmp_reg;
  reg  [1:0]   mask_reg;
  reg  [31:0]  dat_reg;
  reg          ack_reg;
  reg          err_reg;
  reg  [31:0]  rd_data;
  reg          rd_hit;

  wire [1:0]   mode;
  wire         running;
  wire         req;
  wire         wr;
  wire [3:0]   idx;
  wire         addr_ok;
  wire         lo_lane;
  wire [1:0]   status;
  wire         at_zero;
  wire         at_period;
  wire         wrap_evt;
  wire         ccmp_evt;
  wire [W-1:0] shadow;
  wire         halted_at_period;
  wire         wr_chcmp;
  wire [W-1:0] din;
  wire         wr_ctl;
  wire         wr_count;
  wire         wr_period;
  wire         wr_chctl;
  wire         wr_mask;
  wire         wr_status;
  wire         clr_req;
  wire         up_mode;
  wire         zero_hit;
  wire         rd_take;
  wire [W-1:0] cmp_src;
  reg          up_last_reg;

  assign mode    = ctl_reg[`UMT_CTL_MODE_HI:`UMT_CTL_MODE_LO];
  assign running = (mode != `UMT_MODE_STOP);
  assign req     = CYC_I && STB_I && !ack_reg && !err_reg;
  assign idx     = ADR_I[5:2];
  assign addr_ok = (ADR_I[31:6] == 26'h0) && (ADR_I[1:0] == 2'h0) &&
                   (idx <= `UMT_OFS_MASK);
  assign wr      = req && WE_I && addr_ok;
  // Registers are 16 bits or less; only the low two lanes matter
  assign lo_lane = SEL_I[0];
  assign din     = DAT_I[W-1:0];

  assign at_zero   = (count_reg == {W{1'b0}});
  assign at_period = (count_reg == period_reg);
  assign wr_chcmp  = wr && (idx == `UMT_OFS_CHCMP) && (SEL_I[1:0] == 2'h3);
  // Write strobes, one per register
  assign wr_ctl    = wr && lo_lane && (idx == `UMT_OFS_CTL);
  assign wr_count  = wr && (idx == `UMT_OFS_COUNT) && (SEL_I[1:0] == 2'h3);
  assign wr_period = wr && (idx == `UMT_OFS_PERIOD) && (SEL_I[1:0] == 2'h3);
  assign wr_chctl  = wr && lo_lane && (idx == `UMT_OFS_CHCTL);
  assign wr_mask   = wr && lo_lane && (idx == `UMT_OFS_MASK);
  assign wr_status = wr && lo_lane && (idx == `UMT_OFS_STATUS);
  // Reinit is a strobe, never stored in the control register
  assign clr_req   = wr_ctl && DAT_I[`UMT_CTL_CLR_BIT];
  assign up_mode   = (mode == `UMT_MODE_UP);
  // Zero reached by counting, not a count already resting at zero
  assign zero_hit  = running && !at_zero && (count_next == {W{1'b0}});
  // A delayed load takes the stored compare, not whatever is on the bus
  assign cmp_src   = wr_chcmp ? din : chcmp_reg;
  assign rd_take   = req && !WE_I && addr_ok;

  // Next count for each mode; stop holds the value
  always @* begin
    count_next = count_reg;
    case (mode)
      `UMT_MODE_UP: begin
        if (count_reg >= period_reg) begin
          count_next = {W{1'b0}};
        end else begin
          count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
      `UMT_MODE_CONT: begin
        count_next = count_reg + {{(W-1){1'b0}}, 1'b1};
      end
      `UMT_MODE_UPDOWN: begin
        if (dir_down_reg) begin
          count_next = at_zero ? count_reg
                               : count_reg - {{(W-1){1'b0}}, 1'b1};
        end else begin
          count_next = at_period ? count_reg
                                 : count_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
      default: count_next = count_reg;
    endcase
  end

  // Wrap event: the count returns to zero while running
  assign wrap_evt = running && !at_zero && (count_next == {W{1'b0}});
  assign ccmp_evt = running && (count_reg == shadow) &&
                    (count_next != count_reg);

  // Control: the reinit bit reads back as zero
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctl_reg <= `UMT_CTL_RESET;
    end else if (wr_ctl) begin
      ctl_reg <= {1'b0, DAT_I[2:0]};
    end
  end

  // Reinit beats a direct count write, which beats counting
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      count_reg    <= {W{1'b0}};
      dir_down_reg <= 1'b0;
    end else if (clr_req) begin
      count_reg    <= {W{1'b0}};
      dir_down_reg <= 1'b0;
    end else if (wr_count) begin
      count_reg <= din;
    end else begin
      count_reg <= count_next;
      if (mode == `UMT_MODE_UPDOWN) begin
        if (!dir_down_reg && at_period) begin
          dir_down_reg <= 1'b1;
        end else if (dir_down_reg && at_zero) begin
          dir_down_reg <= 1'b0;
        end
      end
    end
  end

  // 16-bit registers change only when both low lanes are selected
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      period_reg <= {W{1'b0}};
    end else if (wr_period) begin
      period_reg <= din;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chctl_reg <= `UMT_CHCTL_RESET;
    end else if (wr_chctl) begin
      chctl_reg <= DAT_I[`UMT_SHADOW_LOAD_EVENT_SELECT_HI:`UMT_SHADOW_LOAD_EVENT_SELECT_LO];
    end
  end

  // Compare register; the shadow latch decides when it takes effect
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      chcmp_reg <= {W{1'b0}};
    end else if (wr_chcmp) begin
      chcmp_reg <= din;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_reg <= 2'h0;
    end else if (wr_mask) begin
      mask_reg <= DAT_I[1:0];
    end
  end

  umt_shadow_latch #(
    .W (W)
  ) u_shadow (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .load_sel  (chctl_reg),
    .up_mode   (up_mode),
    .cmp_write (wr_chcmp),
    .cmp_value (cmp_src),
    .at_zero   (zero_hit),
    .at_period (running && at_period),
    .shadow    (shadow)
  );

  // Status flags; a new event wins over a same-cycle clear
  umt_sync_flag u_wrap_flag (
    .CLK   (CLK),
    .RST_N (RST_N),
    .set   (wrap_evt),
    .clr   (wr_status && DAT_I[`UMT_ST_WRAP]),
    .flag  (status[`UMT_ST_WRAP])
  );

  umt_sync_flag u_ccmp_flag (
    .CLK   (CLK),
    .RST_N (RST_N),
    .set   (ccmp_evt),
    .clr   (wr_status && DAT_I[`UMT_ST_CCMP]),
    .flag  (status[`UMT_ST_CCMP])
  );

  // Timer interrupt needs both the control enable and the mask bit
  assign IRQ = ctl_reg[`UMT_CTL_IE_BIT] && |(status & mask_reg);

  // Known deviation kept so firmware workarounds can be exercised
  assign halted_at_period = !running && at_period && up_last_reg;

  // Reinit forgets the Up mode run even when issued while still running
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      up_last_reg <= 1'b0;
    end else if (clr_req) begin
      up_last_reg <= 1'b0;
    end else if (up_mode) begin
      up_last_reg <= 1'b1;
    end else if (running) begin
      up_last_reg <= 1'b0;
    end
  end

  // Read mux; unused upper bits read as zero
  always @* begin
    rd_data = 32'h0;
    rd_hit  = 1'b1;
    case (idx)
      `UMT_OFS_CTL:    rd_data[3:0] = {1'b0, ctl_reg[2:0]};
      `UMT_OFS_COUNT: begin
        if (halted_at_period) begin
          rd_data[W-1:0] = count_reg ^ `UMT_CORRUPT_XOR;
        end else begin
          rd_data[W-1:0] = count_reg;
        end
      end
      `UMT_OFS_PERIOD: rd_data[W-1:0] = period_reg;
      `UMT_OFS_CHCTL:  rd_data[1:0]   = chctl_reg;
      `UMT_OFS_CHCMP:  rd_data[W-1:0] = chcmp_reg;
      `UMT_OFS_SHADOW: rd_data[W-1:0] = shadow;
      `UMT_OFS_STATUS: rd_data[1:0]   = status;
      `UMT_OFS_MASK:   rd_data[1:0]   = mask_reg;
      default:         rd_hit         = 1'b0;
    endcase
  end

  // One-cycle answer; a pending answer blocks a second take of the request
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= req && addr_ok && rd_hit;
      err_reg <= req && !(addr_ok && rd_hit);
      if (rd_take) begin
        dat_reg <= rd_data;
      end
    end
  end

  assign ACK_O = ack_reg;
  assign ERR_O = err_reg;
  assign DAT_O = dat_reg;
endmodule // umt_timer

// file: verif/umt_timer_checker.sv
// Port assertions for the up mode timer
`timescale 1ns/1ps
module umt_timer_checker (
  input wire        CLK,
  input wire        RST_N,
  input wire [31:0] ADR_I,
  input wire [31:0] DAT_I,
  input wire        WE_I,
  input wire [3:0]  SEL_I,
  input wire        STB_I,
  input wire        CYC_I,
  input wire        ACK_O,
  input wire        ERR_O,
  input wire        IRQ
);
  reg  ie_reg;
  wire take   = CYC_I & STB_I & ~ACK_O & ~ERR_O;
  wire ctl_wr = take & WE_I & SEL_I[0] & (ADR_I == 32'h0);
  wire bad    = (|ADR_I[31:5]) | (|ADR_I[1:0]);
  // Enable copy follows the write edge, not the ack
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      ie_reg <= 1'b0;
    else if (ctl_wr)
      ie_reg <= DAT_I[2];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence req_s;
    take;
  endsequence
  sequence ans_s;
    ##1 (ACK_O ^ ERR_O) ##1 !(ACK_O | ERR_O);
  endsequence
  a_answer_next: assert property (req_s |-> ans_s)
    else $error("request not answered by one pulse");
  a_bus_quiet: assert property (!(CYC_I & STB_I) |=> !(ACK_O | ERR_O))
    else $error("answer without request");
  a_err_unmapped: assert property (take && bad |=> ERR_O && !ACK_O)
    else $error("unmapped access not refused");
  a_irq_gated: assert property (IRQ |-> ie_reg)
    else $error("interrupt while disabled");
  a_irq_off: assert property (ctl_wr && !DAT_I[2] |=> !IRQ)
    else $error("interrupt stays after disable");
endmodule // umt_timer_checker

bind umt_timer umt_timer_checker umt_timer_checker_i (.CLK(CLK),
  .RST_N(RST_N), .ADR_I(ADR_I), .DAT_I(DAT_I), .WE_I(WE_I), .SEL_I(SEL_I),
  .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O), .ERR_O(ERR_O), .IRQ(IRQ));

// file: verif/tb.sv
// Self-checking bench for the up mode timer
`timescale 1ns/1ps
`include "umt_defs.vh"
module tb;
  reg         clk, rst_n, we, cyc, stb, e;
  reg  [31:0] adr, dat, q;
  reg  [3:0]  sel, lanes;
  wire [31:0] dat_o;
  wire        ack_o, err_o, irq;
  integer     miscompares, num_checks, cycles, i;

  umt_timer umt_timer_i (.CLK(clk), .RST_N(rst_n), .ADR_I(adr),
    .DAT_I(dat), .DAT_O(dat_o), .WE_I(we), .SEL_I(sel), .STB_I(stb),
    .CYC_I(cyc), .ACK_O(ack_o), .ERR_O(err_o), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // Ceiling far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      give_verdict;
    end
  end

  task chk(input [31:0] seen, input [31:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        miscompares = miscompares + 1;
        $display("Error at %0t: saw %h, want %h", $time, seen, want);
      end
    end
  endtask

  // One classic cycle; no fixed latency assumed
  task xfer(input w, input [5:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= {24'h0, a, 2'h0};
      dat <= d;
      @(posedge clk);
      while (ack_o !== 1'b1 && err_o !== 1'b1)
        @(posedge clk);
      q = dat_o;
      e = err_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
    end
  endtask

  task wr(input [5:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input [5:0] a, input [31:0] want);
    begin
      xfer(1'b0, a, 32'h0);
      chk(q, want);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 32'h0;
    dat = 32'h0;
    sel = 4'hf;
    lanes = 4'hf;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(`UMT_OFS_CTL, 32'h0);
    rd(`UMT_OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    // Period zero pins the count on the period value
    wr(`UMT_OFS_PERIOD, 32'h0);
    wr(`UMT_OFS_CTL, 32'h1);
    rd(`UMT_OFS_COUNT, 32'h0);
    wr(`UMT_OFS_CTL, 32'h0);
    rd(`UMT_OFS_COUNT, 32'h1);
    wr(`UMT_OFS_CTL, 32'h8);
    rd(`UMT_OFS_COUNT, 32'h0);
    wr(`UMT_OFS_CTL, 32'h3);
    wr(`UMT_OFS_CTL, 32'h0);
    rd(`UMT_OFS_COUNT, 32'h0);
    $display("test halted read done");
    wr(`UMT_OFS_PERIOD, 32'h3);
    wr(`UMT_OFS_CTL, 32'h1);
    for (i = 0; i < 6; i = i + 1) begin
      xfer(1'b0, `UMT_OFS_COUNT, 32'h0);
      chk({31'h0, q > 32'h3}, 32'h0);
    end
    lanes = 4'h0;
    wr(`UMT_OFS_PERIOD, 32'h9);
    lanes = 4'hf;
    rd(`UMT_OFS_PERIOD, 32'h3);
    xfer(1'b0, `UMT_OFS_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    // Continuous mode runs past the period value
    wr(`UMT_OFS_CTL, 32'h2);
    for (i = 0; i < 3; i = i + 1)
      xfer(1'b0, `UMT_OFS_COUNT, 32'h0);
    chk({31'h0, q > 32'h3}, 32'h1);
    wr(`UMT_OFS_CTL, 32'h8);
    $display("test up count done");
    wr(`UMT_OFS_COUNT, 32'h5);
    wr(`UMT_OFS_CHCTL, 32'h0);
    wr(`UMT_OFS_CHCMP, 32'h55);
    rd(`UMT_OFS_SHADOW, 32'h55);
    for (i = 1; i < 3; i = i + 1) begin
      wr(`UMT_OFS_CHCTL, i);
      wr(`UMT_OFS_CHCMP, 32'h100 + i);
      rd(`UMT_OFS_SHADOW, 32'h55);
    end
    wr(`UMT_OFS_PERIOD, 32'h1000);
    wr(`UMT_OFS_CTL, 32'h1);
    for (i = 1; i < 3; i = i + 1) begin
      wr(`UMT_OFS_CHCTL, i);
      wr(`UMT_OFS_CHCMP, 32'h200 + i);
      rd(`UMT_OFS_SHADOW, 32'h200 + i);
    end
    // Load on period match takes the stored compare value
    wr(`UMT_OFS_CHCTL, 32'h3);
    wr(`UMT_OFS_CHCMP, 32'h300);
    rd(`UMT_OFS_SHADOW, 32'h202);
    wr(`UMT_OFS_PERIOD, 32'h0);
    rd(`UMT_OFS_SHADOW, 32'h300);
    wr(`UMT_OFS_CTL, 32'h8);
    $display("test shadow load done");
    wr(`UMT_OFS_MASK, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`UMT_OFS_CTL, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wr(`UMT_OFS_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`UMT_OFS_MASK, 32'h1);
    wr(`UMT_OFS_STATUS, 32'h3);
    chk({31'h0, irq}, 32'h0);
    rd(`UMT_OFS_STATUS, 32'h0);
    $display("test interrupt done");
    xfer(1'b0, 6'h8, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test unmapped done");
    give_verdict;
  end
endmodule // tb
